// file: csm_margin.sv
// Closed-loop margining controller for one supply channel
//
// Contract
// - PWM output repeats at a fixed 62.5 kHz.
// - Duty code is six bits and moves one code at a time.
// - Margining runs only while a margin-high or margin-low state is set.
// - No margining and no PWM until all enabled supplies are power good.
// - On start, enable the PWM and load the seed as duty.
// - Average eight samples over 40 ms; change duty only per window.
// - Step once when the average misses the target by more than 1%.
// - Slope bit 15: 0 means more duty lowers voltage, 1 raises it.
// - Duty at 0% or 100% with target missed is a margin failure (flagged only when the needed step points past that limit).
// - Failure sets the status byte, word, margin bits and ALERT.
// - First average after seeding past the target raises a margin fault.
// - Seed bits 5:0 give the initial duty code for both directions.
// - Configuration bits 14:6 always read back as zero.
// - Seed overshoot reports exactly like a saturation failure.
`timescale 1ns/1ps
`include "csm_params.svh"

module csm_margin
  import csm_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = `CSM_SAMPLE_CYC
)
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Command port
  input  wire logic       cmd_wr,
  input  wire logic       cmd_rd,
  input  wire logic [7:0] cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic [15:0]     cmd_rdata_q,
  output logic            cmd_rvalid_q,
  output logic            cmd_unmapped_q,
  // Operating state and supply status
  input  wire logic       op_margin_high,
  input  wire logic       op_margin_low,
  input  wire logic       all_power_good,
  input  wire logic       alert_enable,
  input  wire logic       clear_faults,
  // Measurement and targets
  input  wire csm_volt_t  vout_data,
  input  wire csm_volt_t  target_high,
  input  wire csm_volt_t  target_low,
  // PWM pin
  output logic            pwm_out,
  output logic            pwm_en_q,
  output csm_duty_t       duty_q,
  // Status bits
  output logic            status_byte_nota,
  output logic            status_word_nota,
  output logic            status_word_mfr,
  output logic            margin_fault,
  // Open-drain alert pin
  input  wire logic       alert_in,
  output logic            alert_out,
  output logic            alert_oe_n
);

  localparam logic [31:0] SAMPLE_LAST = 32'(SAMPLE_CYC - 1);

  csm_state_t  state_q;
  csm_state_t  state_d;
  logic        margin_req;
  logic        run;
  logic        seed_load;
  logic        slope_q;
  csm_duty_t   seed_q;
  logic [31:0] tmr_q;
  logic        sample_tick;
  logic [2:0]  nsamp_q;
  logic [14:0] acc_q;
  logic [14:0] acc_sum;
  csm_volt_t   avg_q;
  logic        win_q;
  csm_volt_t   target;
  csm_volt_t   diff;
  logic        out_of_band;
  logic        need_up;
  logic        step_inc;
  logic        at_limit;
  logic        sat_fault;
  logic        seed_fault;
  logic        fault_evt;
  logic [3:0]  status_q;
  logic        alert_seen;

  ////////////////////////////////////////////////////////////////////////////
  // Command port

  // Configuration word write
  always_ff @(posedge clock) begin
    if (rst) begin
      slope_q <= 1'(`CSM_CFG_RESET >> `CSM_CFG_SLOPE_BIT);
      seed_q  <= 6'(`CSM_CFG_RESET);
    end else if (cmd_wr && cmd_code == `CSM_CMD_MARGIN_CFG) begin
      slope_q <= cmd_wdata[`CSM_CFG_SLOPE_BIT];
      seed_q  <= cmd_wdata[`CSM_CFG_SEED_MSB:`CSM_CFG_SEED_LSB];
    end
  end

  // Read answer one cycle after the request; unknown codes answer zero
  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_rdata_q    <= 16'h0000;
      cmd_rvalid_q   <= 1'b0;
      cmd_unmapped_q <= 1'b0;
    end else begin
      cmd_rvalid_q   <= cmd_rd;
      cmd_unmapped_q <= (cmd_rd || cmd_wr) &&
                        (cmd_code != `CSM_CMD_MARGIN_CFG);
      if (cmd_rd && cmd_code == `CSM_CMD_MARGIN_CFG) begin
        cmd_rdata_q <= {slope_q, 9'h000, seed_q};
      end else if (cmd_rd) begin
        cmd_rdata_q <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing

  assign margin_req = op_margin_high || op_margin_low;
  assign run        = (state_q == st_seeded) || (state_q == st_track);
  assign seed_load  = (state_q == st_wait_pg) && all_power_good;

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_idle: begin
        if (margin_req) begin
          state_d = st_wait_pg;
        end
      end
      st_wait_pg: begin
        if (all_power_good) begin
          state_d = st_seeded;
        end
      end
      st_seeded: begin
        if (win_q) begin
          state_d = st_track;
        end
      end
      st_track: begin
        state_d = st_track;
      end
      default: begin
        state_d = st_idle;
      end
    endcase
    if (!margin_req) begin
      state_d = st_idle;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= st_idle;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Averaging

  // Sample timer, eight ticks per 40 ms window
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      tmr_q <= 32'h0000_0000;
    end else if (tmr_q == SAMPLE_LAST) begin
      tmr_q <= 32'h0000_0000;
    end else begin
      tmr_q <= tmr_q + 32'h0000_0001;
    end
  end

  assign sample_tick = run && (tmr_q == SAMPLE_LAST);
  assign acc_sum     = acc_q + {3'h0, vout_data};

  // Accumulate samples, publish the mean after the eighth
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      acc_q   <= 15'h0000;
      nsamp_q <= 3'h0;
      avg_q   <= 12'h000;
      win_q   <= 1'b0;
    end else begin
      win_q <= 1'b0;
      if (sample_tick && nsamp_q == `CSM_LAST_SAMPLE) begin
        acc_q   <= 15'h0000;
        nsamp_q <= 3'h0;
        avg_q   <= acc_sum[14:3];
        win_q   <= 1'b1;
      end else if (sample_tick) begin
        acc_q   <= acc_sum;
        nsamp_q <= nsamp_q + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control law

  assign target      = op_margin_high ? target_high : target_low;
  assign diff        = (avg_q > target) ? (avg_q - target)
                                        : (target - avg_q);
  // Compare diff * 100 against target * 1 to avoid a divider
  assign out_of_band = (20'(diff) * 20'(`CSM_PCT_SCALE)) >
                       (20'(target) * 20'(`CSM_TOL_PCT));
  assign need_up     = avg_q < target;
  assign step_inc    = (need_up == slope_q);
  assign at_limit    = step_inc ? (duty_q == `CSM_DUTY_MAX)
                                : (duty_q == `CSM_DUTY_MIN);

  // Duty register, seeded on start and stepped once per window
  always_ff @(posedge clock) begin
    if (rst) begin
      duty_q <= 6'h00;
    end else if (seed_load) begin
      duty_q <= seed_q;
    end else if (run && win_q && out_of_band && !at_limit) begin
      if (step_inc) begin
        duty_q <= duty_q + 6'h01;
      end else begin
        duty_q <= duty_q - 6'h01;
      end
    end
  end

  // PWM enable follows the margining run
  always_ff @(posedge clock) begin
    if (rst) begin
      pwm_en_q <= 1'b0;
    end else begin
      pwm_en_q <= run;
    end
  end

  // PWM waveform generator
  csm_pwm u_pwm (
    .clock  (clock),
    .rst    (rst),
    .enable (run),
    .duty   (duty_q),
    .pwm_q  (pwm_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Fault reporting

  assign sat_fault  = run && win_q && out_of_band && at_limit;
  assign seed_fault = (state_q == st_seeded) && win_q &&
                      (op_margin_high ? (avg_q > target)
                                      : (avg_q < target));
  assign fault_evt  = sat_fault || seed_fault;

  // Sticky status bits, a new fault wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      status_q <= 4'h0;
    end else if (fault_evt) begin
      status_q <= 4'hF;
    end else if (clear_faults) begin
      status_q <= 4'h0;
    end
  end

  assign status_byte_nota = status_q[0];
  assign status_word_nota = status_q[1];
  assign status_word_mfr  = status_q[2];
  assign margin_fault     = status_q[3];
  assign alert_seen       = alert_in;

  // Alert drive enable, low while asserted, set only on a new status bit
  always_ff @(posedge clock) begin
    if (rst) begin
      alert_oe_n <= 1'b1;
    end else if (fault_evt && !status_q[3] && alert_enable) begin
      alert_oe_n <= 1'b0;
    end else if (clear_faults) begin
      alert_oe_n <= 1'b1;
    end
  end

  // Open-drain drive: the pin only ever pulls low
  assign alert_out = 1'b0;

endmodule

// file: csm_params.svh
// Constants for the closed-loop supply margining block
`ifndef CSM_PARAMS_SVH
`define CSM_PARAMS_SVH

// Command codes and field layout of the configuration word
`define CSM_CMD_MARGIN_CFG  8'hE0
`define CSM_CFG_SLOPE_BIT   15
`define CSM_CFG_SEED_MSB    5
`define CSM_CFG_SEED_LSB    0
`define CSM_CFG_RESET       16'h0000

// Clock and PWM timing
`define CSM_CLK_HZ          100000000
`define CSM_PWM_FREQ_HZ     62500
`define CSM_PWM_PERIOD_CYC  (`CSM_CLK_HZ / `CSM_PWM_FREQ_HZ)
`define CSM_DUTY_STEPS      64
`define CSM_PWM_TICK_CYC    (`CSM_PWM_PERIOD_CYC / `CSM_DUTY_STEPS)
`define CSM_DUTY_MIN        6'h00
`define CSM_DUTY_MAX        6'h3F

// Averaging window
`define CSM_WINDOW_MS       40
`define CSM_SAMPLES         8
`define CSM_WINDOW_CYC      (`CSM_WINDOW_MS * (`CSM_CLK_HZ / 1000))
`define CSM_SAMPLE_CYC      (`CSM_WINDOW_CYC / `CSM_SAMPLES)
`define CSM_LAST_SAMPLE     3'h7

// Tolerance band in percent
`define CSM_TOL_PCT         12'h001
`define CSM_PCT_SCALE       8'h64

`endif

// file: csm_pkg.sv
// Types for the closed-loop supply margining block
package csm_pkg;

  typedef logic [5:0]  csm_duty_t;
  typedef logic [11:0] csm_volt_t;

  typedef enum logic [1:0] {
    st_idle,
    st_wait_pg,
    st_seeded,
    st_track
  } csm_state_t;

endpackage

// file: csm_pwm.sv
// Fixed-rate PWM generator with 6-bit duty code
`timescale 1ns/1ps
`include "csm_params.svh"

module csm_pwm
  import csm_pkg::*;
(
  // Clock and reset
  input  wire logic      clock,
  input  wire logic      rst,
  // Control
  input  wire logic      enable,
  input  wire csm_duty_t duty,
  // Output
  output logic           pwm_q
);

  localparam logic [4:0] TICK_LAST = 5'(`CSM_PWM_TICK_CYC - 1);

  logic [4:0] div_q;
  logic       tick;
  csm_duty_t  phase_q;

  // Divider giving one enable pulse per duty step
  always_ff @(posedge clock) begin
    if (rst || !enable) begin
      div_q <= 5'h00;
    end else if (div_q == TICK_LAST) begin
      div_q <= 5'h00;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end

  assign tick = enable && (div_q == TICK_LAST);

  // Phase counter, 64 steps make one period of 62.5 kHz
  always_ff @(posedge clock) begin
    if (rst || !enable) begin
      phase_q <= 6'h00;
    end else if (tick) begin
      phase_q <= phase_q + 6'h01;
    end
  end

  // Top code means always on, zero means always off
  always_ff @(posedge clock) begin
    if (rst || !enable) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= (duty == `CSM_DUTY_MAX) || (phase_q < duty);
    end
  end

endmodule

// file: csm_margin_props.sv
// Checker for the supply margining controller ports
`timescale 1ns/1ps
module csm_margin_props
  import csm_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = 20
)
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Command answer
  input wire logic        cmd_rvalid_q,
  input wire logic [15:0] cmd_rdata_q,
  // Operating state
  input wire logic        op_margin_high,
  input wire logic        op_margin_low,
  input wire logic        all_power_good,
  input wire logic        alert_enable,
  input wire logic        clear_faults,
  // Outputs watched
  input wire logic        pwm_out,
  input wire logic        pwm_en_q,
  input wire csm_duty_t   duty_q,
  input wire logic        status_byte_nota,
  input wire logic        status_word_nota,
  input wire logic        status_word_mfr,
  input wire logic        margin_fault,
  input wire logic        alert_oe_n
);
  localparam int GAP_MIN = 8 * SAMPLE_CYC - 2;
  csm_duty_t dprev_q;
  int        gap_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////
  // Cycles since the duty code last moved
  always_ff @(posedge clock) begin
    dprev_q <= rst ? 6'h00 : duty_q;
    gap_q   <= (rst || duty_q != dprev_q) ? 0 : gap_q + 1;
  end
  ////////////////////////////////////////////////////////////////////
  chk_reserved_zero: assert property (cmd_rvalid_q |->
    cmd_rdata_q[14:6] == 9'h000) else $error("reserved bits set");
  chk_status_same: assert property (margin_fault == status_byte_nota
    && margin_fault == status_word_nota && margin_fault == status_word_mfr)
    else $error("status bits disagree");
  chk_fault_sticky: assert property (margin_fault && !clear_faults
    |=> margin_fault) else $error("fault bit lost");
  chk_alert_new: assert property ($fell(alert_oe_n) |->
    $rose(margin_fault) && $past(alert_enable)) else $error("stray alert");
  chk_pwm_idle: assert property (!pwm_en_q && !$past(pwm_en_q)
    |-> !pwm_out) else $error("pwm while stopped");
  chk_run_op: assert property (pwm_en_q |->
    $past(op_margin_high | op_margin_low, 2)) else $error("run w/o op");
  chk_start_pg: assert property ($rose(pwm_en_q) |->
    $past(all_power_good, 2)) else $error("start w/o power good");
  chk_step_one: assert property (pwm_en_q && duty_q != dprev_q
    |-> (duty_q - dprev_q == 6'h01) || (dprev_q - duty_q == 6'h01))
    else $error("duty step not one");
  chk_no_wrap: assert property (pwm_en_q |->
    !(dprev_q == 6'h3F && duty_q == 6'h00)
    && !(dprev_q == 6'h00 && duty_q == 6'h3F)) else $error("duty wrapped");
  chk_window_gap: assert property (pwm_en_q && duty_q != dprev_q
    |-> gap_q >= GAP_MIN) else $error("duty moved mid window");
  cov_start: cover property ($rose(pwm_en_q));
  cov_fault: cover property ($rose(margin_fault));
  cov_alert: cover property ($fell(alert_oe_n));
endmodule
bind csm_margin csm_margin_props #(.SAMPLE_CYC(SAMPLE_CYC))
  csm_margin_props_i (.clock, .rst, .cmd_rvalid_q, .cmd_rdata_q,
  .op_margin_high, .op_margin_low, .all_power_good, .alert_enable,
  .clear_faults, .pwm_out, .pwm_en_q, .duty_q, .status_byte_nota,
  .status_word_nota, .status_word_mfr, .margin_fault, .alert_oe_n);

// file: csm_feedback.sv
// Regulator feedback model: sensed output follows the PWM duty
`timescale 1ns/1ps
module csm_feedback
  import csm_pkg::*;
(
  // Clock
  input  wire logic      clock,
  // PWM side
  input  wire logic      pwm_en,
  input  wire csm_duty_t duty,
  input  wire logic      slope,
  // Sensed output
  output csm_volt_t      vout_q
);
  // Settled filter level, nominal while the PWM is off
  always_ff @(posedge clock) begin
    if (!pwm_en)
      vout_q <= 12'h400;
    else if (slope)
      vout_q <= 12'h400 + {duty, 3'b000};
    else
      vout_q <= 12'h400 - {duty, 3'b000};
  end
endmodule

// file: csm_margin_tb.sv
// Self-checking bench for the supply margining controller
`timescale 1ns/1ps
`define CHECK(a, b) begin n_checks++; if ((a) !== (b)) begin \
  fail_count++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module csm_margin_tb;
  import csm_pkg::*;
  localparam int S = 20;
  logic        clock = 1'b0, rst = 1'b1, slope = 1'b0;
  logic        cmd_wr = 1'b0, cmd_rd = 1'b0, op_margin_high = 1'b0;
  logic [7:0]  cmd_code = 8'h00;
  logic [15:0] cmd_wdata = 16'h0000, cmd_rdata_q;
  logic        op_margin_low = 1'b0, all_power_good = 1'b0;
  logic        alert_enable = 1'b0, clear_faults = 1'b0;
  csm_volt_t   vout_data, target_high = 12'h000, target_low = 12'h000;
  csm_duty_t   duty_q;
  logic        cmd_rvalid_q, cmd_unmapped_q, pwm_out, pwm_en_q;
  logic        status_byte_nota, status_word_nota, status_word_mfr;
  logic        margin_fault, alert_out, alert_oe_n;
  wire         alert_in = alert_oe_n | alert_out; // Pulled up when released
  int          fail_count = 0, n_checks = 0;
  ////////////////////////////////////////////////////////////////////
  csm_margin #(.SAMPLE_CYC(S)) csm_margin_i (.clock, .rst, .cmd_wr,
    .cmd_rd, .cmd_code, .cmd_wdata, .cmd_rdata_q, .cmd_rvalid_q,
    .cmd_unmapped_q, .op_margin_high, .op_margin_low, .all_power_good,
    .alert_enable, .clear_faults, .vout_data, .target_high, .target_low,
    .pwm_out, .pwm_en_q, .duty_q, .status_byte_nota, .status_word_nota,
    .status_word_mfr, .margin_fault, .alert_in, .alert_out, .alert_oe_n);
  csm_feedback csm_feedback_i (.clock, .pwm_en(pwm_en_q), .duty(duty_q),
    .slope, .vout_q(vout_data));
  always #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////
  task automatic cyc(int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(logic [7:0] c, logic [15:0] d);
    cmd_wr = 1'b1;
    cmd_code = c;
    cmd_wdata = d;
    cyc();
    cmd_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] c, logic [15:0] exp);
    cmd_rd = 1'b1;
    cmd_code = c;
    cyc();
    cmd_rd = 1'b0;
    `CHECK(cmd_rvalid_q, 1'b1)
    `CHECK(cmd_rdata_q, exp)
  endtask
  // Configure, enter a margin state, then release power good
  task automatic start(logic hi, logic [15:0] cfg, csm_volt_t tgt);
    wr(8'hE0, cfg);
    slope = cfg[15];
    target_high = hi ? tgt : 12'h000;
    target_low = hi ? 12'h000 : tgt;
    op_margin_high = hi;
    op_margin_low = !hi;
    cyc(5);
    `CHECK(pwm_en_q, 1'b0)
    all_power_good = 1'b1;
    cyc(2);
    `CHECK(pwm_en_q, 1'b1)
    `CHECK(duty_q, cfg[5:0])
    cyc(4 * S);
    `CHECK(duty_q, cfg[5:0])
    cyc(4 * S + 4);
  endtask
  task automatic stop();
    op_margin_high = 1'b0;
    op_margin_low = 1'b0;
    all_power_good = 1'b0;
    clear_faults = 1'b1;
    cyc();
    clear_faults = 1'b0;
    cyc(2);
    `CHECK(pwm_en_q, 1'b0)
    `CHECK({margin_fault, alert_oe_n}, 2'b01)
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_reg();
    rd(8'hE0, 16'h0000);
    wr(8'hE0, 16'hFFFF);
    rd(8'hE0, 16'h803F);
    wr(8'h10, 16'h0000);
    `CHECK(cmd_unmapped_q, 1'b1)
    rd(8'hE0, 16'h803F);
    cyc();
    rd(8'h10, 16'h0000);
    `CHECK(cmd_unmapped_q, 1'b1)
  endtask
  task automatic t_step();
    start(1'b1, 16'h800A, 12'h514);
    `CHECK(duty_q, 6'h0B)
    `CHECK(margin_fault, 1'b0)
    stop();
  endtask
  task automatic t_sat();
    alert_enable = 1'b1;
    start(1'b1, 16'h0000, 12'h514);
    `CHECK(duty_q, 6'h00)
    `CHECK({status_byte_nota, status_word_nota}, 2'b11)
    `CHECK({status_word_mfr, margin_fault}, 2'b11)
    `CHECK({alert_out, alert_oe_n, alert_in}, 3'b000)
    stop();
  endtask
  task automatic t_seed();
    alert_enable = 1'b0;
    start(1'b0, 16'h8000, 12'h44C);
    `CHECK(margin_fault, 1'b1)
    `CHECK(alert_oe_n, 1'b1)
    `CHECK(duty_q, 6'h01)
    stop();
  endtask
  task automatic t_band();
    int   k, r0, per, hi;
    logic p;
    k = 0;
    r0 = 0;
    per = 0;
    hi = 0;
    p = 1'b1;
    start(1'b1, 16'h8020, 12'h500);
    for (int i = 0; i < 3400; i++) begin
      if (pwm_out && !p) begin
        k++;
        if (k == 1) r0 = i;
        if (k == 2) per = i - r0;
      end
      if (k == 1 && pwm_out) hi++;
      p = pwm_out;
      cyc();
    end
    `CHECK(per, 1600)
    `CHECK(hi, 800)
    `CHECK(duty_q, 6'h20)
    stop();
    `CHECK(pwm_out, 1'b0)
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial begin
    cyc(4);
    rst = 1'b0;
    t_reg();
    t_step();
    t_sat();
    t_seed();
    t_band();
    results();
  end
  // Watchdog against a hung handshake
  initial begin
    #500000;
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end
endmodule
